/* hdl/tes_pkg.sv */
// constants shared by the transmit encoder and shaper
package tes_pkg;

   ////////////////////////////////////////////////////////////////////////
   // register offsets
   localparam logic [7:0] TES_ADDR_LINE_STD  = 8'h20;
   localparam logic [7:0] TES_ADDR_TX_IF     = 8'h22;
   localparam logic [7:0] TES_ADDR_SHAPE     = 8'h23;
   localparam logic [7:0] TES_ADDR_SCALE     = 8'h24;
   localparam logic [7:0] TES_ADDR_RAM_CTRL  = 8'h25;
   localparam logic [7:0] TES_ADDR_RAM_VALUE = 8'h26;
   localparam logic [7:0] TES_ADDR_STATUS    = 8'h27;
   localparam logic [7:0] TES_ADDR_EVT_EN    = 8'h28;

   ////////////////////////////////////////////////////////////////////////
   // field positions
   localparam int unsigned TES_STD_BIT     = 0;
   localparam int unsigned TES_IF_CODE_BIT = 0;
   localparam int unsigned TES_IF_RAIL_BIT = 1;
   localparam int unsigned TES_IF_POL_BIT  = 2;
   localparam int unsigned TES_IF_EDGE_BIT = 3;
   localparam int unsigned TES_CTL_SUB_LSB = 0;
   localparam int unsigned TES_CTL_UI_LSB  = 4;
   localparam int unsigned TES_CTL_DIR_BIT = 6;
   localparam int unsigned TES_CTL_TRG_BIT = 7;
   localparam int unsigned TES_ST_LOST_BIT = 0;
   localparam int unsigned TES_ST_OVF_BIT  = 1;
   localparam int unsigned TES_ST_LIVE_BIT = 2;

   ////////////////////////////////////////////////////////////////////////
   // values after reset
   localparam logic [7:0] TES_CFG_RST   = 8'h00;
   localparam logic [5:0] TES_SCALE_RST = 6'h21;

   ////////////////////////////////////////////////////////////////////////
   // counts, codes and limits
   localparam int unsigned  TES_CLK_LOSS_CYCLES = 70;
   localparam int unsigned  TES_SUB_DIV         = 2;
   localparam logic signed [16:0] TES_SCALE_DEN = 17'sh21;
   localparam logic signed [16:0] TES_AMP_MAX   = 17'sh3f;
   localparam logic [1:0]   TES_SHAPE_ARB       = 2'h3;
   localparam logic [3:0]   TES_ROM_EDGE_SUB    = 4'h3;
   localparam logic [3:0]   TES_ROM_FIRST_SUB   = 4'h4;
   localparam logic [3:0]   TES_ROM_LAST_SUB    = 4'hb;

   // peak sample of each of the twelve reference templates
   localparam logic [6:0] TES_ROM_PEAK [12] = '{
      7'h30, 7'h3c, 7'h36, 7'h38, 7'h3a, 7'h3c, 7'h3e, 7'h3a,
      7'h3c, 7'h19, 7'h0b, 7'h04};

   // symbol codes held in the substitution pipe
   localparam logic [1:0] TES_SYM_ZERO = 2'h0;
   localparam logic [1:0] TES_SYM_MARK = 2'h1;
   localparam logic [1:0] TES_SYM_VIOL = 2'h2;

   typedef enum logic [3:0] {
      TES_ST_IDLE  = 4'b0001,
      TES_ST_ISSUE = 4'b0010,
      TES_ST_WAIT  = 4'b0100,
      TES_ST_DONE  = 4'b1000
   } tes_ram_state_t;

endpackage

/* hdl/tes_wave_ram.sv */
// waveform sample memory, one write port and several registered read ports
`timescale 1ns/100ps
module tes_wave_ram #(
   parameter int unsigned AW  = 6,
   parameter int unsigned DW  = 7,
   parameter int unsigned NRD = 5
) (
   input  wire logic                clk,
   input  wire logic                rst_n,
   input  wire logic                we,
   input  wire logic [AW-1:0]       waddr,
   input  wire logic [DW-1:0]       wdata,
   input  wire logic [NRD*AW-1:0]   raddr,
   output logic      [NRD*DW-1:0]   rdata
);

   logic [DW-1:0]     mem_ff [2**AW];
   logic [NRD*DW-1:0] rdata_ff;

   always_ff @(posedge clk) begin
      if (we) begin
         mem_ff[waddr] <= wdata;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rdata_ff <= '0;
      end else begin
         for (int i = 0; i < NRD; i++) begin
            rdata_ff[i*DW +: DW] <= mem_ff[raddr[i*AW +: AW]];
         end
      end
   end

   assign rdata = rdata_ff;

endmodule

/* hdl/tes_tx_encoder_shaper.sv */
// transmit line encoder and pulse shaper for one channel
//
// How it works
// - line standard bit 0 selects E1, 1 selects T1/J1.
// - no transmit clock edge for over 70 cycles flags loss, event unless masked.
// - data sampled on rising or falling transmit clock edge by choice bit.
// - polarity bit makes data inputs active high or active low.
// - rail mode 0 uses single input only; 1 uses both rail inputs.
// - T1/J1 single rail encodes B8ZS or AMI by line code choice.
// - E1 single rail encodes HDB3 or AMI by line code choice.
// - dual rail bypasses the encoder in every line standard.
// - dual rail pos-only gives negative pulse, neg-only positive, equal gives space.
// - E1 shape 0000 is 75 ohm template, 0001 is 120 ohm.
// - T1 has five preset templates by cable grade via shape select.
// - long haul attenuates in four 7.5 dB grades using three build-outs.
// - shape select 11xx plays the waveform from the programmable RAM.
// - pulse spans four intervals of sixteen sub-phase samples each.
// - samples are seven-bit sign-magnitude, +63 to -63 full scale.
// - per-channel 64-byte RAM addressed by interval and sub-phase index.
// - twelve reference templates live in a local read-only store.
// - setting the trigger bit performs the RAM access; repeat per sample.
// - six-bit step field scales the whole arbitrary waveform up or down.
// - step resets to 100001, each unit changing amplitude by about 3%.
// - summed overlap beyond limit sets overflow flag, event if enabled.
// - scaling is ignored for preset templates and build-out settings.
`timescale 1ns/100ps
module tes_tx_encoder_shaper #(
   parameter int unsigned SUB_DIV = tes_pkg::TES_SUB_DIV
) (
   input  wire logic       clk,
   input  wire logic       arst_n,
   input  wire logic [7:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   input  wire logic       reg_wr,
   input  wire logic       reg_rd,
   output logic      [7:0] reg_rdata,
   input  wire logic       tx_clock_in,
   input  wire logic       tx_data_single,
   input  wire logic       tx_data_pos_rail,
   input  wire logic       tx_data_neg_rail,
   output logic      [6:0] line_output_pair,
   output logic            line_pos_mark,
   output logic            line_neg_mark,
   output logic            clock_lost,
   output logic            irq
);

   ////////////////////////////////////////////////////////////////////////
   // functions

   // sign-magnitude sample to two's complement
   function automatic logic signed [9:0] sm_to_int(input logic [6:0] sm);
      logic signed [9:0] mag;
      mag = $signed({4'h0, sm[5:0]});
      return sm[6] ? -mag : mag;
   endfunction

   // reference template store: single interval pulse with a shoulder
   function automatic logic signed [9:0] rom_sample(input logic [3:0] tpl,
                                                    input logic [1:0] ui,
                                                    input logic [3:0] sub);
      logic [6:0] peak;
      peak = tes_pkg::TES_ROM_PEAK[tpl];
      if (ui != 2'h0) begin
         return 10'sh000;
      end else if (sub == tes_pkg::TES_ROM_EDGE_SUB) begin
         return sm_to_int({1'b0, 2'h0, peak[5:2]});
      end else if (sub >= tes_pkg::TES_ROM_FIRST_SUB &&
                   sub <= tes_pkg::TES_ROM_LAST_SUB) begin
         return sm_to_int(peak);
      end
      return 10'sh000;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // reset release and input synchronisers

   logic [1:0] rst_sync_ff;
   logic       rst_n;
   logic [3:0] pin_s1_ff;
   logic [3:0] pin_s2_ff;
   logic       clk_prev_ff;

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rst_sync_ff <= 2'h0;
      end else begin
         rst_sync_ff <= {rst_sync_ff[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_ff[1];

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pin_s1_ff   <= 4'h0;
         pin_s2_ff   <= 4'h0;
         clk_prev_ff <= 1'b0;
      end else begin
         pin_s1_ff   <= {tx_clock_in, tx_data_single, tx_data_pos_rail,
                         tx_data_neg_rail};
         pin_s2_ff   <= pin_s1_ff;
         clk_prev_ff <= pin_s2_ff[3];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // configuration registers

   logic [7:0] std_ff;
   logic [7:0] if_ff;
   logic [3:0] shape_ff;
   logic [5:0] step_ff;
   logic [7:0] ctrl_ff;
   logic [6:0] value_ff;
   logic [1:0] status_ff;
   logic [1:0] evt_en_ff;
   logic [7:0] rdata_ff;
   logic [7:0] nxt_rdata;

   logic line_std;
   logic code_choice;
   logic rail_mode;
   logic data_pol;
   logic edge_choice;
   logic arb_mode;
   assign line_std    = std_ff[tes_pkg::TES_STD_BIT];
   assign code_choice = if_ff[tes_pkg::TES_IF_CODE_BIT];
   assign rail_mode   = if_ff[tes_pkg::TES_IF_RAIL_BIT];
   assign data_pol    = if_ff[tes_pkg::TES_IF_POL_BIT];
   assign edge_choice = if_ff[tes_pkg::TES_IF_EDGE_BIT];
   assign arb_mode    = shape_ff[3:2] == tes_pkg::TES_SHAPE_ARB;

   logic wr_std, wr_if, wr_shape, wr_step, wr_ctrl, wr_value;
   logic wr_status, wr_en;
   assign wr_std    = reg_wr && reg_addr == tes_pkg::TES_ADDR_LINE_STD;
   assign wr_if     = reg_wr && reg_addr == tes_pkg::TES_ADDR_TX_IF;
   assign wr_shape  = reg_wr && reg_addr == tes_pkg::TES_ADDR_SHAPE;
   assign wr_step   = reg_wr && reg_addr == tes_pkg::TES_ADDR_SCALE;
   assign wr_ctrl   = reg_wr && reg_addr == tes_pkg::TES_ADDR_RAM_CTRL;
   assign wr_value  = reg_wr && reg_addr == tes_pkg::TES_ADDR_RAM_VALUE;
   assign wr_status = reg_wr && reg_addr == tes_pkg::TES_ADDR_STATUS;
   assign wr_en     = reg_wr && reg_addr == tes_pkg::TES_ADDR_EVT_EN;

   ////////////////////////////////////////////////////////////////////////
   // transmit clock edge detection and loss supervision

   logic       tclk_now;
   logic       any_edge;
   logic       bit_strobe;
   logic       d_single, d_pos, d_neg;
   logic [6:0] loss_cnt_ff;
   logic       lost_ff;
   logic       lost_level;

   assign tclk_now   = pin_s2_ff[3];
   assign any_edge   = tclk_now ^ clk_prev_ff;
   assign bit_strobe = edge_choice ? (clk_prev_ff & ~tclk_now)
                                   : (~clk_prev_ff & tclk_now);
   assign d_single   = pin_s2_ff[2] ^ data_pol;
   assign d_pos      = pin_s2_ff[1] ^ data_pol;
   assign d_neg      = pin_s2_ff[0] ^ data_pol;
   assign lost_level = loss_cnt_ff > 7'(tes_pkg::TES_CLK_LOSS_CYCLES);

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         loss_cnt_ff <= 7'h00;
         lost_ff     <= 1'b0;
      end else begin
         if (any_edge) begin
            loss_cnt_ff <= 7'h00;
         end else if (!lost_level) begin
            loss_cnt_ff <= loss_cnt_ff + 7'h01;
         end
         lost_ff <= lost_level;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // line encoder: zero substitution pipe then alternate mark inversion

   logic [15:0] pipe_ff;
   logic        parity_ff;
   logic        last_pos_ff;
   logic        data_in;
   logic [15:0] shift_in;
   logic        b8zs_hit;
   logic        hdb3_hit;
   logic [15:0] nxt_pipe;
   logic [7:0]  hdb3_fill;
   logic [1:0]  old_sym;
   logic        enc_mark, enc_pos;
   logic        sym_pos, sym_neg;

   assign data_in  = ~rail_mode & d_single;
   assign shift_in = {pipe_ff[13:0],
                      data_in ? tes_pkg::TES_SYM_MARK : tes_pkg::TES_SYM_ZERO};
   assign b8zs_hit = ~rail_mode & line_std & code_choice
                     & (shift_in == 16'h0000);
   assign hdb3_hit = ~rail_mode & ~line_std & code_choice
                     & (shift_in[7:0] == 8'h00);
   assign hdb3_fill = parity_ff
      ? {tes_pkg::TES_SYM_ZERO, tes_pkg::TES_SYM_ZERO,
         tes_pkg::TES_SYM_ZERO, tes_pkg::TES_SYM_VIOL}
      : {tes_pkg::TES_SYM_MARK, tes_pkg::TES_SYM_ZERO,
         tes_pkg::TES_SYM_ZERO, tes_pkg::TES_SYM_VIOL};
   assign nxt_pipe = b8zs_hit
      ? {tes_pkg::TES_SYM_ZERO, tes_pkg::TES_SYM_ZERO,
         tes_pkg::TES_SYM_ZERO, tes_pkg::TES_SYM_VIOL,
         tes_pkg::TES_SYM_MARK, tes_pkg::TES_SYM_ZERO,
         tes_pkg::TES_SYM_VIOL, tes_pkg::TES_SYM_MARK}
      : hdb3_hit ? {shift_in[15:8], hdb3_fill} : shift_in;

   // a violation repeats the previous mark polarity, a mark alternates
   assign old_sym  = pipe_ff[15:14];
   assign enc_mark = old_sym != tes_pkg::TES_SYM_ZERO;
   assign enc_pos  = enc_mark & ((old_sym == tes_pkg::TES_SYM_VIOL)
                                 ? last_pos_ff : ~last_pos_ff);

   // dual rail skips the encoder entirely
   assign sym_pos = rail_mode ? (~d_pos & d_neg) : enc_pos;
   assign sym_neg = rail_mode ? (d_pos & ~d_neg)
                              : (enc_mark & ~enc_pos);

   logic [3:0] hist_pos_ff;
   logic [3:0] hist_neg_ff;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pipe_ff     <= 16'h0000;
         parity_ff   <= 1'b0;
         last_pos_ff <= 1'b0;
         hist_pos_ff <= 4'h0;
         hist_neg_ff <= 4'h0;
      end else if (bit_strobe) begin
         pipe_ff     <= nxt_pipe;
         parity_ff   <= hdb3_hit ? 1'b0 : parity_ff ^ data_in;
         last_pos_ff <= (enc_mark && !rail_mode) ? enc_pos : last_pos_ff;
         hist_pos_ff <= {hist_pos_ff[2:0], sym_pos};
         hist_neg_ff <= {hist_neg_ff[2:0], sym_neg};
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // sub-phase timing within each unit interval

   logic [7:0] div_ff;
   logic [3:0] sub_ff;
   logic [3:0] sub_d_ff;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         div_ff   <= 8'h00;
         sub_ff   <= 4'h0;
         sub_d_ff <= 4'h0;
      end else begin
         sub_d_ff <= sub_ff;
         if (bit_strobe) begin
            div_ff <= 8'h00;
            sub_ff <= 4'h0;
         end else if (div_ff == 8'(SUB_DIV - 1)) begin
            div_ff <= 8'h00;
            sub_ff <= (sub_ff == 4'hf) ? sub_ff : sub_ff + 4'h1;
         end else begin
            div_ff <= div_ff + 8'h01;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // waveform RAM and its software access sequencer

   tes_pkg::tes_ram_state_t ram_st_ff, nxt_ram_st;
   logic [5:0]  sw_addr;
   logic        sw_dir;
   logic        ram_we;
   logic [29:0] ram_raddr;
   logic [34:0] ram_rdata;

   assign sw_addr = {ctrl_ff[tes_pkg::TES_CTL_UI_LSB +: 2],
                     ctrl_ff[tes_pkg::TES_CTL_SUB_LSB +: 4]};
   assign sw_dir  = ctrl_ff[tes_pkg::TES_CTL_DIR_BIT];
   assign ram_we  = (ram_st_ff == tes_pkg::TES_ST_ISSUE) & ~sw_dir;
   // four lanes follow the last four symbols, the fifth serves software
   assign ram_raddr = {sw_addr, 2'h3, sub_ff, 2'h2, sub_ff,
                       2'h1, sub_ff, 2'h0, sub_ff};

   tes_wave_ram #(
      .AW  (6),
      .DW  (7),
      .NRD (5)
   ) u_wave_ram (
      .clk   (clk),
      .rst_n (rst_n),
      .we    (ram_we),
      .waddr (sw_addr),
      .wdata (value_ff),
      .raddr (ram_raddr),
      .rdata (ram_rdata)
   );

   always_comb begin
      nxt_ram_st = ram_st_ff;
      case (ram_st_ff)
         tes_pkg::TES_ST_IDLE: begin
            if (ctrl_ff[tes_pkg::TES_CTL_TRG_BIT]) begin
               nxt_ram_st = tes_pkg::TES_ST_ISSUE;
            end
         end
         tes_pkg::TES_ST_ISSUE: nxt_ram_st = tes_pkg::TES_ST_WAIT;
         tes_pkg::TES_ST_WAIT:  nxt_ram_st = tes_pkg::TES_ST_DONE;
         tes_pkg::TES_ST_DONE:  nxt_ram_st = tes_pkg::TES_ST_IDLE;
         default:               nxt_ram_st = tes_pkg::TES_ST_IDLE;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // shaper: overlap of four intervals, scaling and clamping

   logic signed [9:0]  shp_sum;
   logic signed [16:0] shp_prod;
   logic signed [16:0] shp_amp;
   logic signed [16:0] shp_mag;
   logic               shp_ovf;
   logic [6:0]         nxt_line;
   logic [6:0]         line_ff;

   always_comb begin
      logic signed [9:0] smp;
      smp     = 10'sh000;
      shp_sum = 10'sh000;
      for (int k = 0; k < 4; k++) begin
         smp = arb_mode ? sm_to_int(ram_rdata[k*7 +: 7])
                        : rom_sample(shape_ff, 2'(k), sub_d_ff);
         if (hist_pos_ff[k]) begin
            shp_sum = shp_sum + smp;
         end else if (hist_neg_ff[k]) begin
            shp_sum = shp_sum - smp;
         end
      end
   end

   // step 33 is unity gain, so one step is close to three percent
   assign shp_prod = 17'(shp_sum * $signed({1'b0, step_ff}));
   assign shp_amp  = arb_mode ? shp_prod / tes_pkg::TES_SCALE_DEN
                              : 17'(shp_sum);
   assign shp_mag  = shp_amp < 0 ? -shp_amp : shp_amp;
   assign shp_ovf  = arb_mode && (shp_sum > 10'sh03f || shp_sum < -10'sh03f);
   assign nxt_line = {shp_amp < 0,
                      shp_mag > tes_pkg::TES_AMP_MAX ? 6'h3f
                                                     : shp_mag[5:0]};

   ////////////////////////////////////////////////////////////////////////
   // register file

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         std_ff    <= tes_pkg::TES_CFG_RST;
         if_ff     <= tes_pkg::TES_CFG_RST;
         shape_ff  <= 4'h0;
         step_ff   <= tes_pkg::TES_SCALE_RST;
         ctrl_ff   <= tes_pkg::TES_CFG_RST;
         value_ff  <= 7'h00;
         status_ff <= 2'h0;
         evt_en_ff <= 2'h0;
         ram_st_ff <= tes_pkg::TES_ST_IDLE;
         line_ff   <= 7'h00;
         rdata_ff  <= 8'h00;
      end else begin
         ram_st_ff <= nxt_ram_st;
         line_ff   <= nxt_line;
         if (wr_std)   std_ff   <= reg_wdata;
         if (wr_if)    if_ff    <= reg_wdata;
         if (wr_shape) shape_ff <= reg_wdata[3:0];
         if (wr_step)  step_ff  <= reg_wdata[5:0];
         if (wr_en)    evt_en_ff <= reg_wdata[1:0];
         // a software write of the trigger wins over the automatic clear
         if (wr_ctrl) begin
            ctrl_ff <= reg_wdata;
         end else if (ram_st_ff == tes_pkg::TES_ST_DONE) begin
            ctrl_ff[tes_pkg::TES_CTL_TRG_BIT] <= 1'b0;
         end
         if (wr_value) begin
            value_ff <= reg_wdata[6:0];
         end else if (ram_st_ff == tes_pkg::TES_ST_WAIT && sw_dir) begin
            value_ff <= ram_rdata[34:28];
         end
         // sticky flags, new events win over a write-one clear
         status_ff <= (status_ff & ~(wr_status ? reg_wdata[1:0] : 2'h0))
                      | {shp_ovf, lost_level & ~lost_ff};
         rdata_ff  <= reg_rd ? nxt_rdata : 8'h00;
      end
   end

   assign nxt_rdata =
      reg_addr == tes_pkg::TES_ADDR_LINE_STD  ? std_ff :
      reg_addr == tes_pkg::TES_ADDR_TX_IF     ? if_ff :
      reg_addr == tes_pkg::TES_ADDR_SHAPE     ? {4'h0, shape_ff} :
      reg_addr == tes_pkg::TES_ADDR_SCALE     ? {2'h0, step_ff} :
      reg_addr == tes_pkg::TES_ADDR_RAM_CTRL  ? ctrl_ff :
      reg_addr == tes_pkg::TES_ADDR_RAM_VALUE ? {1'b0, value_ff} :
      reg_addr == tes_pkg::TES_ADDR_STATUS    ? {5'h00, lost_ff, status_ff} :
      reg_addr == tes_pkg::TES_ADDR_EVT_EN    ? {6'h00, evt_en_ff} :
      8'h00;

   ////////////////////////////////////////////////////////////////////////
   // outputs

   assign reg_rdata        = rdata_ff;
   assign line_output_pair = line_ff;
   assign line_pos_mark    = hist_pos_ff[0];
   assign line_neg_mark    = hist_neg_ff[0];
   assign clock_lost       = lost_ff;
   assign irq              = |(status_ff & evt_en_ff);

endmodule

/* testbench/tes_tx_encoder_shaper_props.sv */
// port assertions for the transmit encoder and shaper
`timescale 1ns/100ps
module tes_tx_encoder_shaper_props (
   input wire logic       clk,
   input wire logic       arst_n,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic       reg_wr,
   input wire logic       reg_rd,
   input wire logic [7:0] reg_rdata,
   input wire logic       tx_clock_in,
   input wire logic       tx_data_pos_rail,
   input wire logic       tx_data_neg_rail,
   input wire logic       line_pos_mark,
   input wire logic       line_neg_mark,
   input wire logic       clock_lost,
   input wire logic       irq
);
   logic [7:0] quiet_ff, stb_ff, if_ff;
   logic [3:0] age_ff;
   logic       std_ff, en_ff, scw_ff, tclk_ff, p_ff, n_ff;
   wire logic wr_std = reg_wr && reg_addr == 8'h20;
   wire logic wr_if  = reg_wr && reg_addr == 8'h22;
   wire logic wr_trg = reg_wr && reg_addr == 8'h25 && reg_wdata[7];
   wire logic rd_ctl = reg_rd && reg_addr == 8'h25;
   wire logic chg    = tx_data_pos_rail != p_ff || tx_data_neg_rail != n_ff;
   wire logic pos_in = tx_data_pos_rail ^ if_ff[2];
   wire logic neg_in = tx_data_neg_rail ^ if_ff[2];
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         {quiet_ff, stb_ff, if_ff} <= '0;
         {std_ff, en_ff, scw_ff, tclk_ff, p_ff, n_ff} <= '0;
         age_ff <= 4'hf;
      end else begin
         {tclk_ff, p_ff, n_ff} <= {tx_clock_in, tx_data_pos_rail, tx_data_neg_rail};
         quiet_ff <= (tx_clock_in != tclk_ff) ? 8'h0 : quiet_ff + {7'h0, quiet_ff != 8'hff};
         stb_ff <= (chg || wr_std || wr_if) ? 8'h0 : stb_ff + {7'h0, stb_ff != 8'hff};
         age_ff <= wr_trg ? 4'h0 : age_ff + {3'h0, age_ff != 4'hf};
         if (wr_if) if_ff <= reg_wdata;
         if (wr_std) std_ff <= reg_wdata[0];
         if (reg_wr && reg_addr == 8'h28) en_ff <= reg_wdata[0];
         if (reg_wr && reg_addr == 8'h24) scw_ff <= 1'b1;
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);
   property p_lost_quiet; $rose(clock_lost) |-> quiet_ff >= 8'h44; endproperty
   a_lost_quiet: assert property (p_lost_quiet)
      else $error("clock loss flagged too early");
   property p_lost_set; quiet_ff == 8'h5a |-> clock_lost; endproperty
   a_lost_set: assert property (p_lost_set)
      else $error("clock loss not flagged");
   property p_lost_clr;
      clock_lost && tx_clock_in != tclk_ff |-> ##[1:8] !clock_lost;
   endproperty
   a_lost_clr: assert property (p_lost_clr)
      else $error("clock loss not cleared by edge");
   property p_irq_loss; $rose(clock_lost) && en_ff |-> ##[0:2] irq; endproperty
   a_irq_loss: assert property (p_irq_loss)
      else $error("no event on clock loss");
   property p_std_rb;
      reg_rd && reg_addr == 8'h20 |=> reg_rdata == {7'h0, std_ff};
   endproperty
   a_std_rb: assert property (p_std_rb)
      else $error("line standard readback wrong");
   property p_scale_rst;
      reg_rd && reg_addr == 8'h24 && !scw_ff |=> reg_rdata == 8'h21;
   endproperty
   a_scale_rst: assert property (p_scale_rst)
      else $error("step field reset value wrong");
   property p_one_mark; !(line_pos_mark && line_neg_mark); endproperty
   a_one_mark: assert property (p_one_mark)
      else $error("both marks at once");
   property p_trg_busy; rd_ctl && age_ff <= 4'h1 |=> reg_rdata[7]; endproperty
   a_trg_busy: assert property (p_trg_busy)
      else $error("trigger not held during access");
   property p_trg_done; rd_ctl && age_ff >= 4'h5 |=> !reg_rdata[7]; endproperty
   a_trg_done: assert property (p_trg_done)
      else $error("trigger not cleared");
   property p_dual;
      if_ff[1] && stb_ff >= 8'hc8 && !clock_lost |->
         line_neg_mark == (pos_in && !neg_in) && line_pos_mark == (neg_in && !pos_in);
   endproperty
   a_dual: assert property (p_dual)
      else $error("dual rail mark wrong");
   c_lost: cover property ($rose(clock_lost));
   c_ram: cover property (rd_ctl && age_ff >= 4'h5);
   c_dual: cover property (if_ff[1] && stb_ff >= 8'hc8);
endmodule
bind tes_tx_encoder_shaper tes_tx_encoder_shaper_props tes_tx_encoder_shaper_props_i (
   .clk(clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
   .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
   .tx_clock_in(tx_clock_in), .tx_data_pos_rail(tx_data_pos_rail),
   .tx_data_neg_rail(tx_data_neg_rail), .line_pos_mark(line_pos_mark),
   .line_neg_mark(line_neg_mark), .clock_lost(clock_lost), .irq(irq));

/* testbench/tes_framer_model.sv */
// framer model: transmit clock and rail data, clock still and data toggling while run is low
`timescale 1ns/100ps
module tes_framer_model (
   input  wire logic run,
   input  wire logic pos,
   input  wire logic neg,
   output logic      tclk,
   output logic      d_pos,
   output logic      d_neg
);
   initial begin
      {tclk, d_pos, d_neg} = 3'b001;
      forever begin
         #40;
         if (run) begin
            d_pos = pos;
            d_neg = neg;
            #40 tclk = 1'b1;
            #80 tclk = 1'b0;
         end else begin
            d_pos = ~d_pos;
            d_neg = ~d_neg;
         end
      end
   end
endmodule

/* testbench/test_tes_tx_encoder_shaper.sv */
// self-checking bench for the transmit encoder and shaper
`timescale 1ns/100ps
`define CHK(nm, e, s) \
   begin \
      checks++; \
      if ((s) !== (e)) begin \
         fails++; \
         $display("[FAIL] %s expected %h seen %h", nm, e, s); \
      end \
   end
module test_tes_tx_encoder_shaper;
   logic       clk, arst_n, reg_wr, reg_rd, run, fp, fn, sp, sn, op, on;
   logic       line_pos_mark, line_neg_mark, clock_lost, irq, tclk, dp, dn;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, d;
   logic [6:0] lo;
   int         fails, checks, cyc;
   logic [7:0]  ra [9] = '{8'h20, 8'h22, 8'h23, 8'h24, 8'h25, 8'h26, 8'h27,
                          8'h28, 8'h30};
   logic [11:0] mt [11] = '{12'h000, 12'h103, 12'h010, 12'h113, 12'h00b,
                           12'h209, 12'h216, 12'h20c, 12'h60a, 12'ha09, 12'h408};
   logic [15:0] rt [3] = '{16'h003f, 16'h3f7f, 16'h2a15};
   tes_framer_model tes_framer_model_i (.run(run), .pos(fp), .neg(fn),
      .tclk(tclk), .d_pos(dp), .d_neg(dn));
   tes_tx_encoder_shaper tes_tx_encoder_shaper_i (
      .clk(clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .tx_clock_in(tclk), .tx_data_single(dp), .tx_data_pos_rail(dp),
      .tx_data_neg_rail(dn), .line_output_pair(lo),
      .line_pos_mark(line_pos_mark), .line_neg_mark(line_neg_mark),
      .clock_lost(clock_lost), .irq(irq));
   initial clk = 1'b0;
   always #2 clk = ~clk;
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", checks, fails);
      if (fails == 0 && checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc == 40000) begin
         fails++;
         end_of_test();
      end
   end
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      {reg_addr, reg_wdata, reg_wr} <= {a, v, 1'b1};
      @(posedge clk);
      reg_wr <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] v);
      {reg_addr, reg_rd} <= {a, 1'b1};
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 v = reg_rdata;
      @(posedge clk);
   endtask
   task automatic ram_wait();
      int n = 0;
      d = 8'h80;
      while (d[7] && n < 20) begin
         rd(8'h25, d);
         n++;
      end
      `CHK("trigger", 1'b0, d[7])
   endtask
   task automatic mark_case(input logic [11:0] c);
      wr(8'h20, {7'h0, c[4]});
      wr(8'h22, {4'h0, c[11:8]});
      {fp, fn} <= c[3:2];
      repeat (800) @(posedge clk);
      {sp, sn, op, on} = 4'h0;
      repeat (800) begin
         @(negedge clk);
         {sp, sn} = {sp | line_pos_mark, sn | line_neg_mark};
         {op, on} = {op | (|lo & ~lo[6]), on | lo[6]};
      end
      `CHK("marks", {c[1:0], c[1:0]}, {sp, sn, op, on})
   endtask
   initial begin
      {arst_n, reg_wr, reg_rd, reg_addr, reg_wdata, fp, fn} = '0;
      run = 1'b1;
      repeat (5) @(posedge clk);
      arst_n <= 1'b1;
      repeat (3) @(posedge clk);
      foreach (ra[i]) begin
         rd(ra[i], d);
         `CHK("reset value", (ra[i] == 8'h24) ? 8'h21 : 8'h00, d)
      end
      wr(8'h23, 8'h07);
      rd(8'h23, d);
      `CHK("shape", 8'h07, d)
      $display("register test done");
      foreach (rt[i]) begin
         wr(8'h26, rt[i][7:0]);
         wr(8'h25, 8'h80 | rt[i][15:8]);
         ram_wait();
         wr(8'h26, 8'h00);
         wr(8'h25, 8'hc0 | rt[i][15:8]);
         ram_wait();
         rd(8'h26, d);
         `CHK("ram", rt[i][7:0], d)
      end
      $display("waveform memory test done");
      foreach (mt[i]) mark_case(mt[i]);
      $display("line code test done");
      wr(8'h28, 8'h01);
      run <= 1'b0;
      repeat (150) @(posedge clk);
      `CHK("lost", 1'b1, clock_lost)
      `CHK("irq", 1'b1, irq)
      rd(8'h27, d);
      `CHK("status", 8'h05, d)
      run <= 1'b1;
      repeat (100) @(posedge clk);
      wr(8'h27, 8'h01);
      rd(8'h27, d);
      `CHK("status cleared", 8'h00, d)
      `CHK("irq off", 1'b0, irq)
      $display("clock loss test done");
      end_of_test();
   end
endmodule
